// ===== src/rac_regs.svh
// Register offsets, field masks, reset values for the register shell
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH

// Byte offsets on the 8-bit CPU data bus
`define RAC_OFS_CTRL       4'h0
`define RAC_OFS_STATUS     4'h1
`define RAC_OFS_CMD        4'h2
`define RAC_OFS_OUT        4'h4
`define RAC_OFS_OUT_SET    4'h5
`define RAC_OFS_OUT_CLEAR  4'h6
`define RAC_OFS_OUT_TOGGLE 4'h7
`define RAC_OFS_DBGCTRL    4'h8

// Implemented-bit masks; zero bits are reserved
`define RAC_CTRL_MASK    8'h7F
`define RAC_STATUS_MASK  8'h0F
`define RAC_CMD_MASK     8'h0F
`define RAC_OUT_MASK     8'hFF
`define RAC_DBGCTRL_MASK 8'h01

// Reset values
`define RAC_CTRL_RST     8'h00
`define RAC_CMD_RST      8'h00
`define RAC_OUT_RST      8'h00
`define RAC_DBGCTRL_RST  8'h00

// Value returned when a write-only register is read
`define RAC_WO_READ      8'h00

`endif

// ===== src/rac_pkg.sv
// Types shared by the register shell
package rac_pkg;
	typedef enum logic [3:0] {
		RAC_OP_NONE   = 4'h1,
		RAC_OP_SET    = 4'h2,
		RAC_OP_CLEAR  = 4'h4,
		RAC_OP_TOGGLE = 4'h8
	} rac_alias_op_t;
endpackage

// ===== src/rac_alias_bit.sv
// Shared-register bit updater for set, clear, toggle and plain write
`timescale 1ns/100ps
module rac_alias_bit (
	input  wire logic [7:0]             cur,
	input  wire logic [7:0]             wrData,
	input  wire logic                   wrBase,
	input  wire rac_pkg::rac_alias_op_t op,
	output logic      [7:0]             nxt
);
	genvar i;
	// One updater per bit; a zero in an alias write keeps the bit
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			always_comb begin
				if (wrBase) begin
					nxt[i] = wrData[i];
				end else if (!wrData[i]) begin
					nxt[i] = cur[i]; // RULE12
				end else begin
					case (op)
						rac_pkg::RAC_OP_SET:    nxt[i] = 1'b1; // RULE9
						rac_pkg::RAC_OP_CLEAR:  nxt[i] = 1'b0; // RULE8
						rac_pkg::RAC_OP_TOGGLE: nxt[i] = ~cur[i]; // RULE10
						default:                nxt[i] = cur[i];
					endcase
				end
			end
		end
	endgenerate
endmodule

// ===== src/rac_reg_bank.sv
// Register bank shell applying the access conventions
// Function
// RULE1: A read/write bit reads back its stored value and takes written data.
// RULE2: A read-only bit reports live state and ignores writes.
// RULE3: A write-only bit takes writes and reads as a value not to be used.
// RULE4: Reserved bits always read as zero.
// RULE5: Software writes zero to reserved bits and uses no reserved codes.
// RULE6: Power-on and peripheral soft reset load reset values, except debug.
// RULE7: Base and its set, clear, toggle aliases all read the base contents.
// RULE8: A one written to the clear alias clears the base bit.
// RULE9: A one written to the set alias sets the base bit.
// RULE10: A one written to the toggle alias inverts the base bit.
// RULE11: Alias changes complete in the single write access.
// RULE12: Zero bits in an alias write leave the base bit unchanged.
`timescale 1ns/100ps
`include "rac_regs.svh"
module rac_reg_bank (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clkEn,
	input  wire logic       softReset,
	input  wire logic [3:0] addr,
	input  wire logic       wrEn,
	input  wire logic       rdEn,
	input  wire logic [7:0] wrData,
	input  wire logic [3:0] statusIn,
	output logic      [7:0] rdData,
	output logic      [6:0] ctrlOut,
	output logic      [3:0] cmdOut,
	output logic      [7:0] pinOut,
	output logic            dbgHalt
);
	logic [6:0]            ctrl_ff;
	logic [3:0]            cmd_ff;
	logic [7:0]            out_ff;
	logic [0:0]            dbg_ff;
	logic [3:0]            statMeta_ff;
	logic [3:0]            stat_ff;
	logic [7:0]            rdData_ff;
	logic [7:0]            nxt_out;
	logic [7:0]            nxt_rdData;
	logic                  hitOut;
	logic                  wrOutBase;
	rac_pkg::rac_alias_op_t aliasOp;

	// Two-flop sync of external status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			statMeta_ff <= 4'h0;
			stat_ff     <= 4'h0;
		end else if (clkEn) begin
			statMeta_ff <= statusIn;
			stat_ff     <= statMeta_ff; // RULE2
		end
	end

	// Alias decode for the output register group
	always_comb begin
		aliasOp = rac_pkg::RAC_OP_NONE;
		if (wrEn && addr == `RAC_OFS_OUT_SET) begin
			aliasOp = rac_pkg::RAC_OP_SET;
		end else if (wrEn && addr == `RAC_OFS_OUT_CLEAR) begin
			aliasOp = rac_pkg::RAC_OP_CLEAR;
		end else if (wrEn && addr == `RAC_OFS_OUT_TOGGLE) begin
			aliasOp = rac_pkg::RAC_OP_TOGGLE;
		end
	end

	assign wrOutBase = wrEn && (addr == `RAC_OFS_OUT);
	assign hitOut    = wrOutBase || (aliasOp != rac_pkg::RAC_OP_NONE);

	rac_alias_bit u_alias (
		.cur    (out_ff),
		.wrData (wrData),
		.wrBase (wrOutBase),
		.op     (aliasOp),
		.nxt    (nxt_out)
	);

	// Output register; alias writes land in one cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_ff <= `RAC_OUT_RST;
		end else if (clkEn) begin
			if (softReset) begin
				out_ff <= `RAC_OUT_RST; // RULE6
			end else if (hitOut) begin
				out_ff <= nxt_out; // RULE11
			end
		end
	end

	// Control register, read/write, reserved top bit dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= 7'(`RAC_CTRL_RST);
		end else if (clkEn) begin
			if (softReset) begin
				ctrl_ff <= 7'(`RAC_CTRL_RST); // RULE6
			end else if (wrEn && addr == `RAC_OFS_CTRL) begin
				ctrl_ff <= wrData[6:0]; // RULE1
			end
		end
	end

	// Command register, write-only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_ff <= 4'(`RAC_CMD_RST);
		end else if (clkEn) begin
			if (softReset) begin
				cmd_ff <= 4'(`RAC_CMD_RST); // RULE6
			end else if (wrEn && addr == `RAC_OFS_CMD) begin
				cmd_ff <= wrData[3:0]; // RULE3
			end
		end
	end

	// Debug control, survives peripheral soft reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dbg_ff <= 1'b0;
		end else if (clkEn) begin
			if (wrEn && addr == `RAC_OFS_DBGCTRL) begin
				dbg_ff <= wrData[0]; // RULE6
			end
		end
	end

	// Read mux; reserved and unmapped bits read zero
	always_comb begin
		nxt_rdData = 8'h00;
		if (addr == `RAC_OFS_CTRL) begin
			nxt_rdData = {1'b0, ctrl_ff} & `RAC_CTRL_MASK; // RULE4
		end else if (addr == `RAC_OFS_STATUS) begin
			nxt_rdData = {4'h0, stat_ff}; // RULE2
		end else if (addr == `RAC_OFS_CMD) begin
			nxt_rdData = `RAC_WO_READ; // RULE3
		end else if (addr == `RAC_OFS_OUT || addr == `RAC_OFS_OUT_SET ||
				addr == `RAC_OFS_OUT_CLEAR ||
				addr == `RAC_OFS_OUT_TOGGLE) begin
			nxt_rdData = out_ff; // RULE7
		end else if (addr == `RAC_OFS_DBGCTRL) begin
			nxt_rdData = {7'h00, dbg_ff};
		end
	end

	// Registered read data, updated on read strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_ff <= 8'h00;
		end else if (clkEn && rdEn) begin
			rdData_ff <= nxt_rdData;
		end
	end

	assign rdData  = rdData_ff;
	assign ctrlOut = ctrl_ff;
	assign cmdOut  = cmd_ff;
	assign pinOut  = out_ff;
	assign dbgHalt = dbg_ff;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Alias writes that soft reset does not override
	sequence s_setWr;
		clkEn && !softReset && wrEn && addr == `RAC_OFS_OUT_SET;
	endsequence
	sequence s_clearWr;
		clkEn && !softReset && wrEn && addr == `RAC_OFS_OUT_CLEAR;
	endsequence
	sequence s_toggleWr;
		clkEn && !softReset && wrEn && addr == `RAC_OFS_OUT_TOGGLE;
	endsequence

	// Plain writes to the base, control and command registers
	sequence s_baseWr;
		clkEn && !softReset && wrEn && addr == `RAC_OFS_OUT;
	endsequence
	sequence s_ctrlWr;
		clkEn && !softReset && wrEn && addr == `RAC_OFS_CTRL;
	endsequence
	sequence s_cmdWr;
		clkEn && !softReset && wrEn && addr == `RAC_OFS_CMD;
	endsequence

	// Debug control writes pass even during soft reset
	sequence s_dbgWr;
		clkEn && wrEn && addr == `RAC_OFS_DBGCTRL;
	endsequence

	set_alias_a: assert property (s_setWr |=> // RULE9
		out_ff == ($past(out_ff) | $past(wrData)))
		else $error("set alias wrong");
	clear_alias_a: assert property (s_clearWr |=> // RULE8
		out_ff == ($past(out_ff) & ~$past(wrData)))
		else $error("clear alias wrong");
	toggle_alias_a: assert property (s_toggleWr |=> // RULE10
		out_ff == ($past(out_ff) ^ $past(wrData)))
		else $error("toggle alias wrong");
	alias_keep_a: assert property ( // RULE12
		(s_setWr or s_clearWr or s_toggleWr) |=>
		((out_ff ^ $past(out_ff)) & ~$past(wrData)) == 8'h00)
		else $error("alias touched zero bits");
	ctrl_rw_a: assert property (clkEn && !softReset && wrEn && // RULE1
		addr == `RAC_OFS_CTRL |=> ctrlOut == $past(wrData[6:0]))
		else $error("ctrl write lost");
	alias_read_a: assert property (clkEn && rdEn && // RULE7
		addr inside {`RAC_OFS_OUT_SET, `RAC_OFS_OUT_CLEAR,
		`RAC_OFS_OUT_TOGGLE}
		|=> rdData == $past(out_ff))
		else $error("alias read differs");
	rsvd_zero_a: assert property (clkEn && rdEn && // RULE4
		addr == `RAC_OFS_CTRL |=> rdData[7] == 1'b0)
		else $error("reserved bit set");
	soft_rst_a: assert property (clkEn && softReset |=> // RULE6
		out_ff == `RAC_OUT_RST && ctrl_ff == 7'(`RAC_CTRL_RST) &&
		dbg_ff == $past(dbg_ff))
		else $error("soft reset wrong");

	// Base write lands in one cycle
	base_wr_a: assert property (s_baseWr |=> // RULE1
		pinOut == $past(wrData))
		else $error("base write lost");

	// Base read returns the stored byte
	base_read_a: assert property (clkEn && rdEn && // RULE7
		addr == `RAC_OFS_OUT |=> rdData == $past(out_ff))
		else $error("base read differs");

	// Control read returns stored bits
	ctrl_read_a: assert property (clkEn && rdEn && // RULE1
		addr == `RAC_OFS_CTRL |=> rdData == {1'b0, $past(ctrl_ff)})
		else $error("ctrl read wrong");

	// Control holds when not written
	ctrl_keep_a: assert property (clkEn && !softReset && // RULE1
		!(wrEn && addr == `RAC_OFS_CTRL) |=> $stable(ctrl_ff))
		else $error("ctrl changed unwritten");

	// Command holds when not written
	cmd_keep_a: assert property (clkEn && !softReset && // RULE3
		!(wrEn && addr == `RAC_OFS_CMD) |=> $stable(cmd_ff))
		else $error("cmd changed unwritten");

	// Command reads the fixed write-only value
	cmd_read_a: assert property (clkEn && rdEn && // RULE3
		addr == `RAC_OFS_CMD |=> rdData == `RAC_WO_READ)
		else $error("cmd read wrong");

	// Command clears on soft reset
	soft_cmd_a: assert property (clkEn && softReset |=> // RULE6
		cmd_ff == 4'(`RAC_CMD_RST))
		else $error("cmd soft reset wrong");

	// Debug control takes its written bit
	dbg_wr_a: assert property (s_dbgWr |=> // RULE6
		dbgHalt == $past(wrData[0]))
		else $error("dbg write lost");

	// Debug control holds otherwise
	dbg_keep_a: assert property (clkEn && // RULE6
		!(wrEn && addr == `RAC_OFS_DBGCTRL) |=> $stable(dbg_ff))
		else $error("dbg changed unwritten");

	// Output register idle without a group write
	out_keep_a: assert property (clkEn && !softReset && // RULE12
		!hitOut |=> $stable(out_ff))
		else $error("out changed unwritten");

	// Status follows the synchroniser only
	stat_sync_a: assert property (clkEn |=> // RULE2
		stat_ff == $past(statMeta_ff))
		else $error("status not synced");

	// Unmapped offsets read zero
	unmapped_zero_a: assert property (clkEn && rdEn && // RULE4
		addr inside {4'h3, [4'h9:4'hF]} |=> rdData == 8'h00)
		else $error("unmapped read nonzero");

	// Read data holds between reads
	rd_hold_a: assert property (clkEn && !rdEn |=>
		$stable(rdData))
		else $error("read data moved");

	// Low clock enable freezes every register
	freeze_a: assert property (!clkEn |=>
		$stable(out_ff) && $stable(ctrl_ff) && $stable(cmd_ff) &&
		$stable(dbg_ff) && $stable(stat_ff) && $stable(rdData_ff))
		else $error("state moved while frozen");
	status_ro_a: assert property (clkEn && rdEn && // RULE2
		addr == `RAC_OFS_STATUS |=> rdData == {4'h0, $past(stat_ff)})
		else $error("status read wrong");
	cmd_wo_a: assert property (clkEn && !softReset && wrEn && // RULE3
		addr == `RAC_OFS_CMD |=> cmdOut == $past(wrData[3:0]))
		else $error("cmd write lost");
endmodule

// ===== dv/tb_top.sv
// Self-checking testbench for the register bank shell
`timescale 1ns/100ps
`include "rac_regs.svh"
module tb_top;
	logic       clk;
	logic       reset_n;
	logic       clkEn;
	logic       softReset;
	logic [3:0] addr;
	logic       wrEn;
	logic       rdEn;
	logic [7:0] wrData;
	logic [3:0] statusIn;
	logic [7:0] rdData;
	logic [6:0] ctrlOut;
	logic [3:0] cmdOut;
	logic [7:0] pinOut;
	logic       dbgHalt;
	int         bad_count;
	int         num_checks;
	int         cycleCount;

	// Design under test
	rac_reg_bank uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
		.softReset(softReset), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
		.wrData(wrData), .statusIn(statusIn), .rdData(rdData),
		.ctrlOut(ctrlOut), .cmdOut(cmdOut), .pinOut(pinOut),
		.dbgHalt(dbgHalt));

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	// Counts and closes the run
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compare with four-state equality
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask

	// One-cycle write strobe, outputs settled at the falling edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wrData <= d;
		wrEn   <= 1'b1;
		@(posedge clk);
		wrEn   <= 1'b0;
		@(negedge clk);
	endtask

	// One-cycle read strobe, data taken one cycle later
	task automatic rd(input logic [3:0] a, input logic [7:0] exp,
		input string what);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		@(negedge clk);
		chk(rdData, exp, what);
	endtask

	// Values after power-on reset and an unmapped read
	task automatic test_reset();
		chk({1'b0, ctrlOut}, 8'h00, "ctrl reset");
		chk({7'h00, dbgHalt}, 8'h00, "dbg reset");
		rd(`RAC_OFS_OUT, `RAC_OUT_RST, "out reset");
		rd(`RAC_OFS_CTRL, `RAC_CTRL_RST, "ctrl rd reset");
		rd(4'hF, 8'h00, "unmapped read");
	endtask

	// Read/write bits with a reserved top bit
	task automatic test_rw();
		wr(`RAC_OFS_CTRL, 8'h7F);
		chk({1'b0, ctrlOut}, 8'h7F, "ctrl out");
		rd(`RAC_OFS_CTRL, 8'h7F, "ctrl reserved");
		wr(`RAC_OFS_CTRL, 8'h2A);
		rd(`RAC_OFS_CTRL, 8'h2A, "ctrl rw");
	endtask

	// Read-only status ignores writes
	task automatic test_ro();
		@(posedge clk);
		statusIn <= 4'h5;
		repeat (5) @(posedge clk);
		rd(`RAC_OFS_STATUS, 8'h05, "status live");
		wr(`RAC_OFS_STATUS, 8'h0A);
		rd(`RAC_OFS_STATUS, 8'h05, "status kept");
	endtask

	// Write-only command register
	task automatic test_wo();
		wr(`RAC_OFS_CMD, 8'h0A);
		chk({4'h0, cmdOut}, 8'h0A, "cmd taken");
		rd(`RAC_OFS_CMD, `RAC_WO_READ, "cmd read");
	endtask

	// Set, clear and toggle aliases, with an idle cycle between writes
	task automatic test_alias();
		wr(`RAC_OFS_OUT, 8'hF0);
		chk(pinOut, 8'hF0, "out base");
		wr(`RAC_OFS_OUT_SET, 8'h0F);
		chk(pinOut, 8'hFF, "set alias");
		wr(`RAC_OFS_OUT_CLEAR, 8'h3C);
		chk(pinOut, 8'hC3, "clear alias");
		wr(`RAC_OFS_OUT_TOGGLE, 8'hA5);
		chk(pinOut, 8'h66, "toggle alias");
		for (int i = 4; i < 8; i++) begin
			rd(4'(i), 8'h66, "pair read");
		end
	endtask

	// Frozen write, unmapped write, read data hold
	task automatic test_freeze();
		@(posedge clk);
		clkEn  <= 1'b0;
		addr   <= `RAC_OFS_OUT;
		wrData <= 8'h5A;
		wrEn   <= 1'b1;
		@(posedge clk);
		wrEn   <= 1'b0;
		clkEn  <= 1'b1;
		@(negedge clk);
		chk(pinOut, 8'h66, "frozen write");
		wr(4'hF, 8'h00);
		chk(pinOut, 8'h66, "unmapped write");
		chk({1'b0, ctrlOut}, 8'h2A, "unmapped ctrl");
		rd(`RAC_OFS_CTRL, 8'h2A, "ctrl before hold");
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(rdData, 8'h2A, "read data hold");
	endtask

	// Soft reset clears ctrl, cmd and out but not debug control
	task automatic test_soft();
		wr(`RAC_OFS_DBGCTRL, 8'h01);
		chk({7'h00, dbgHalt}, 8'h01, "dbg set");
		@(posedge clk);
		softReset <= 1'b1;
		@(posedge clk);
		softReset <= 1'b0;
		@(negedge clk);
		chk({1'b0, ctrlOut}, `RAC_CTRL_RST, "ctrl soft");
		chk({4'h0, cmdOut}, `RAC_CMD_RST, "cmd soft");
		chk(pinOut, `RAC_OUT_RST, "out soft");
		chk({7'h00, dbgHalt}, 8'h01, "dbg kept");
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycleCount++;
		if (cycleCount > 2000) begin
			bad_count++;
			$display("Error at %0t: timeout", $time);
			report_and_stop();
		end
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		clkEn = 1'b1;
		softReset = 1'b0;
		addr = 4'h0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		wrData = 8'h00;
		statusIn = 4'h0;
		bad_count = 0;
		num_checks = 0;
		cycleCount = 0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		test_reset();
		test_rw();
		test_ro();
		test_wo();
		test_alias();
		test_freeze();
		test_soft();
		report_and_stop();
	end
endmodule
